// [core/prsr_params.svh]
`ifndef PRSR_PARAMS_SVH
`define PRSR_PARAMS_SVH

// Seven-bit bus address answered on the two-wire port.
`define PRSR_ADDR          7'h28
// System clock rate in MHz.
`define PRSR_CLK_MHZ       125
// Regular update interval in microseconds.
`define PRSR_UPDATE_US     500
// Extra time added by the maintenance cycle, in microseconds.
`define PRSR_SPECIAL_US    400
// One maintenance cycle every this many conversions, minus one as a terminal count.
`define PRSR_SPECIAL_LAST  8'hFE
// Widths of the measured values.
`define PRSR_PRESS_W       14
`define PRSR_TEMP_W        11
`define PRSR_SAMPLE_W      25
// Frame of four bytes, 32 bits.
`define PRSR_FRAME_BITS    6'h20
`define PRSR_LAST_BIT      4'h7
`define PRSR_LAST_BYTE     2'h3
// Status codes placed in the two top bits of the first byte.
`define PRSR_ST_FRESH      2'h0
`define PRSR_ST_STALE      2'h2
// Depth of the sample FIFO.
`define PRSR_FIFO_DEPTH    16

`endif

// [core/prsr_pkg.sv]
`include "prsr_params.svh"
`default_nettype none

package prsr_pkg;

  // Two-wire slave states.
  typedef enum logic [2:0] {
    I2C_IDLE,
    I2C_ADDR,
    I2C_ADDR_ACK,
    I2C_TX,
    I2C_TX_ACK,
    I2C_SINK
  } prsr_i2c_t;

  // All state of the readout on the system clock.
  typedef struct packed {
    logic [16:0]                conv_cnt;
    logic [7:0]                 cyc_cnt;
    logic                       special;
    logic                       pend;
    logic [`PRSR_SAMPLE_W-1:0]  pend_word;
    logic [`PRSR_SAMPLE_W-1:0]  sample;
    logic                       fresh;
    logic                       scl_s1;
    logic                       scl_s2;
    logic                       scl_d;
    logic                       sda_s1;
    logic                       sda_s2;
    logic                       sda_d;
    logic                       ss_s1;
    logic                       ss_s2;
    logic                       ss_d;
    logic                       mode_s1;
    logic                       mode_s2;
    logic [5:0]                 gray_s1;
    logic [5:0]                 gray_s2;
    prsr_i2c_t                  state;
    logic [3:0]                 bitcnt;
    logic [1:0]                 bytecnt;
    logic [7:0]                 shreg;
    logic                       edges;
    logic                       ack;
    logic                       err;
    logic [31:0]                tx_word;
    logic [31:0]                spi_word;
    logic                       sda_oe;
    logic                       miso;
    logic                       miso_oe;
  } prsr_state_t;

  // State on the serial clock of the three-wire port.
  typedef struct packed {
    logic [5:0] bin;
    logic [5:0] gray;
  } prsr_link_t;

endpackage : prsr_pkg

`default_nettype wire

// [core/prsr_fifo.sv]
`default_nettype none

// Synchronous FIFO with valid and ready on both sides.
module prsr_fifo #(
  parameter int unsigned WIDTH = 25,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);

  localparam int unsigned AW = $clog2(DEPTH);

  // Pointers carry one extra bit to tell full from empty.
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } prsr_fifo_ptr_t;

  prsr_fifo_ptr_t   q_r;               // Registered pointers.
  prsr_fifo_ptr_t   q_nxt;             // Next pointers.
  logic [WIDTH-1:0] mem [DEPTH];       // Storage array.
  logic             full;              // No room left.
  logic             empty;             // Nothing stored.

  assign full        = (q_r.wp[AW] != q_r.rp[AW]) && (q_r.wp[AW-1:0] == q_r.rp[AW-1:0]);
  assign empty       = (q_r.wp == q_r.rp);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[q_r.rp[AW-1:0]];

  // Pointers advance on each accepted push and pop.
  always_comb begin
    q_nxt = q_r;
    if (in_valid_i && !full) begin
      q_nxt.wp = q_r.wp + 1'b1;
    end
    if (out_ready_i && !empty) begin
      q_nxt.rp = q_r.rp + 1'b1;
    end
  end

  // Pointer register with synchronous reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Storage is written only when there is room.
  always_ff @(posedge clk_i) begin
    if (in_valid_i && !full) begin
      mem[q_r.wp[AW-1:0]] <= in_data_i;
    end
  end

endmodule : prsr_fifo

`default_nettype wire

// [core/prsr_readout.sv]
// Contract
// RQ1: Convert continuously from reset, flag first result.
// RQ2: Every 255th conversion is 400 us longer.
// RQ3: Idle two-wire bus is never pulled low.
// RQ4: Host makes every START, opening each request.
// RQ5: Host sends seven-bit address plus direction bit.
// RQ6: Bytes MSB first, receiver acks ninth pulse.
// RQ7: On NACK the sensor goes inactive.
// RQ8: Read sends four bytes, stops at NACK.
// RQ9: Two pressure bytes, then eleven temperature bits.
// RQ10: START then STOP without clock errs next.
// RQ11: Repeated START mid-transfer stalls likewise.
// RQ12: Host holds data steady until first clock.
// RQ13: Host changes data only while clock low.
// RQ14: Host makes every STOP to end transfers.
// RQ15: Three-wire port only reads, continuous conversion.
// RQ16: Three-wire port: clock, select, data out.
// RQ17: Host may end three-wire read early.
// RQ18: Host should poll slowly and check status.
// RQ19: Status in top two bits of byte one.
`include "prsr_params.svh"
`default_nettype none

module prsr_readout #(
  parameter int unsigned UPDATE_CYC = `PRSR_UPDATE_US * `PRSR_CLK_MHZ,
  parameter int unsigned EXTRA_CYC  = `PRSR_SPECIAL_US * `PRSR_CLK_MHZ
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic [`PRSR_PRESS_W-1:0] pressure_i,
  input  wire logic [`PRSR_TEMP_W-1:0]  temperature_i,
  input  wire logic                     spi_mode_i,
  input  wire logic                     scl_i,
  input  wire logic                     sda_i,
  output logic                          sda_o,
  output logic                          sda_oe_o,
  input  wire logic                     spi_sclk_i,
  input  wire logic                     spi_ss_n_i,
  output logic                          miso_o,
  output logic                          miso_oe_o,
  output logic                          data_ready_o
);

  // Terminal counts of a regular and of a maintenance conversion.
  localparam logic [16:0] LIM_NORM = 17'(UPDATE_CYC - 1);
  localparam logic [16:0] LIM_SPEC = 17'(UPDATE_CYC + EXTRA_CYC - 1);

  prsr_pkg::prsr_state_t q_r;           // All system-clock state.
  prsr_pkg::prsr_state_t q_nxt;         // Next value of that state.
  prsr_pkg::prsr_link_t  lk_r;          // Serial-clock edge counter.
  prsr_pkg::prsr_link_t  lk_nxt;        // Next value of the edge counter.

  logic                       fifo_in_ready;   // FIFO can take a result.
  logic                       fifo_out_valid;  // FIFO holds a result.
  logic [`PRSR_SAMPLE_W-1:0]  fifo_out_data;   // Oldest stored result.
  logic                       fifo_pop;        // Readout takes a result.
  logic [5:0]                 spi_bin;         // Edge count in binary.
  logic                       conv_done;       // Conversion finishes now.
  logic                       busy;            // A host read is running.
  logic [31:0]                frame;           // Four-byte answer word.
  logic                       scl_rise;        // Synced clock rose.
  logic                       scl_fall;        // Synced clock fell.
  logic                       i2c_start;       // START seen on the bus.
  logic                       i2c_stop;        // STOP seen on the bus.
  logic                       ss_fall;         // Select was just asserted.

  // The data pin is open drain: only its enable ever changes.
  assign sda_o        = 1'b0;
  assign sda_oe_o     = q_r.sda_oe;
  assign miso_o       = q_r.miso;
  assign miso_oe_o    = q_r.miso_oe;
  assign data_ready_o = q_r.fresh;

  // Gray count from the serial clock domain back to binary, one bit each.
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_gray2bin
      assign spi_bin[gi] = ^q_r.gray_s2[5:gi];
    end
  endgenerate

  // Events on the two-wire pins and the select pin, taken only from second-stage flops and their one-cycle delayed copies.
  assign scl_rise  = q_r.scl_s2 && !q_r.scl_d;
  assign scl_fall  = !q_r.scl_s2 && q_r.scl_d;
  assign i2c_start = q_r.scl_s2 && q_r.scl_d && q_r.sda_d && !q_r.sda_s2;
  assign i2c_stop  = q_r.scl_s2 && q_r.scl_d && !q_r.sda_d && q_r.sda_s2;
  assign ss_fall   = q_r.ss_d && !q_r.ss_s2;

  // The result register must not move under a host that is reading.
  assign busy     = (q_r.state != prsr_pkg::I2C_IDLE) || (q_r.mode_s2 && !q_r.ss_s2);
  assign fifo_pop = fifo_out_valid && !busy;

  // A conversion finishes when its interval runs out and the last result left.
  assign conv_done = !q_r.pend && (q_r.conv_cnt == (q_r.special ? LIM_SPEC : LIM_NORM));

  // Answer word: status, 14 pressure bits, 11 temperature bits, padding.
  assign frame = {(q_r.fresh ? `PRSR_ST_FRESH : `PRSR_ST_STALE), // RQ19
                  q_r.sample,                                      // RQ9
                  5'h00};

  // Buffer between the converter and the readout result register.
  prsr_fifo #(
    .WIDTH (`PRSR_SAMPLE_W),
    .DEPTH (`PRSR_FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (q_r.pend),
    .in_data_i   (q_r.pend_word),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (fifo_out_valid),
    .out_data_o  (fifo_out_data),
    .out_ready_i (fifo_pop)
  );

  // Next-state logic for the converter, result register and both ports.
  always_comb begin
    q_nxt = q_r;

    // Pin synchronisers, two flops deep.
    q_nxt.scl_s1  = scl_i;
    q_nxt.scl_s2  = q_r.scl_s1;
    q_nxt.scl_d   = q_r.scl_s2;
    q_nxt.sda_s1  = sda_i;
    q_nxt.sda_s2  = q_r.sda_s1;
    q_nxt.sda_d   = q_r.sda_s2;
    q_nxt.ss_s1   = spi_ss_n_i;
    q_nxt.ss_s2   = q_r.ss_s1;
    q_nxt.ss_d    = q_r.ss_s2;
    q_nxt.mode_s1 = spi_mode_i;
    q_nxt.mode_s2 = q_r.mode_s1;
    q_nxt.gray_s1 = lk_r.gray;
    q_nxt.gray_s2 = q_r.gray_s1;

    // Free-running conversion; the counter stops at its terminal count while a result waits.
    if (conv_done) begin
      q_nxt.conv_cnt  = '0;                                     // RQ1
      q_nxt.pend      = 1'b1;
      q_nxt.pend_word = {pressure_i, temperature_i};
      if (q_r.cyc_cnt == `PRSR_SPECIAL_LAST) begin
        q_nxt.cyc_cnt = '0;
        q_nxt.special = 1'b1;                                   // RQ2
      end else begin
        q_nxt.cyc_cnt = q_r.cyc_cnt + 8'h01;
        q_nxt.special = 1'b0;
      end
    end else if (q_r.conv_cnt != (q_r.special ? LIM_SPEC : LIM_NORM)) begin
      q_nxt.conv_cnt = q_r.conv_cnt + 17'h00001;
    end

    // A waiting result leaves once the FIFO accepts it.
    if (q_r.pend && fifo_in_ready) begin
      q_nxt.pend = 1'b0;
    end

    // Two-wire START and STOP handling, including the stall cases.
    if (i2c_start) begin
      q_nxt.sda_oe = 1'b0;
      q_nxt.bitcnt = '0;
      q_nxt.edges  = 1'b0;
      if (q_r.err) begin
        // This START only clears the stall; the transaction is ignored.
        q_nxt.err   = 1'b0;                                     // RQ10
        q_nxt.state = prsr_pkg::I2C_SINK;
      end else if ((q_r.state == prsr_pkg::I2C_TX) || (q_r.state == prsr_pkg::I2C_TX_ACK)) begin
        // A restart in the middle of data stalls the port.
        q_nxt.err   = 1'b1;                                     // RQ11
        q_nxt.state = prsr_pkg::I2C_SINK;
      end else begin
        q_nxt.state = prsr_pkg::I2C_ADDR;
      end
    end else if (i2c_stop) begin
      // START then STOP with no clock edge poisons the next transaction.
      if ((q_r.state == prsr_pkg::I2C_ADDR) && !q_r.edges) begin
        q_nxt.err = 1'b1;                                       // RQ10
      end
      q_nxt.state  = prsr_pkg::I2C_IDLE;
      q_nxt.sda_oe = 1'b0;                                      // RQ3
    end else begin
      unique case (q_r.state)
        prsr_pkg::I2C_IDLE: begin
          // Bus idle: the data line is left released.
          q_nxt.sda_oe = 1'b0;                                  // RQ3
        end
        prsr_pkg::I2C_ADDR: begin
          // Shift in address and direction, most significant bit first.
          if (scl_rise) begin
            q_nxt.shreg  = {q_r.shreg[6:0], q_r.sda_s2};        // RQ6
            q_nxt.bitcnt = q_r.bitcnt + 4'h1;
            q_nxt.edges  = 1'b1;
          end else if (scl_fall && (q_r.bitcnt == 4'h8)) begin
            if (q_r.shreg[7:1] == `PRSR_ADDR) begin
              // Acknowledge our own address in the ninth slot.
              q_nxt.sda_oe = 1'b1;                              // RQ6
              q_nxt.state  = prsr_pkg::I2C_ADDR_ACK;
            end else begin
              q_nxt.state  = prsr_pkg::I2C_SINK;
            end
          end
        end
        prsr_pkg::I2C_ADDR_ACK: begin
          // End of the ack slot: a read starts sending, a write is ignored.
          if (scl_fall) begin
            q_nxt.bitcnt  = '0;
            q_nxt.bytecnt = '0;
            if (q_r.shreg[0]) begin
              q_nxt.tx_word = frame;                            // RQ8
              q_nxt.sda_oe  = !frame[31];
              q_nxt.fresh   = 1'b0;
              q_nxt.state   = prsr_pkg::I2C_TX;
            end else begin
              q_nxt.sda_oe  = 1'b0;
              q_nxt.state   = prsr_pkg::I2C_SINK;
            end
          end
        end
        prsr_pkg::I2C_TX: begin
          // Each falling clock presents the next bit; after eight, release.
          if (scl_fall) begin
            q_nxt.tx_word = {q_r.tx_word[30:0], 1'b0};          // RQ6
            if (q_r.bitcnt == `PRSR_LAST_BIT) begin
              q_nxt.sda_oe = 1'b0;
              q_nxt.state  = prsr_pkg::I2C_TX_ACK;
            end else begin
              q_nxt.sda_oe = !q_r.tx_word[30];
              q_nxt.bitcnt = q_r.bitcnt + 4'h1;
            end
          end
        end
        prsr_pkg::I2C_TX_ACK: begin
          // Sample the host's answer, then go on or fall silent.
          if (scl_rise) begin
            q_nxt.ack = !q_r.sda_s2;
          end else if (scl_fall) begin
            if (q_r.ack && (q_r.bytecnt != `PRSR_LAST_BYTE)) begin
              q_nxt.bytecnt = q_r.bytecnt + 2'h1;               // RQ8
              q_nxt.bitcnt  = '0;
              q_nxt.sda_oe  = !q_r.tx_word[31];
              q_nxt.state   = prsr_pkg::I2C_TX;
            end else begin
              q_nxt.sda_oe  = 1'b0;                             // RQ7
              q_nxt.state   = prsr_pkg::I2C_SINK;
            end
          end
        end
        prsr_pkg::I2C_SINK: begin
          // Inactive until the host sends START or STOP.
          q_nxt.sda_oe = 1'b0;                                  // RQ7
        end
      endcase
    end

    // Three-wire port: a read-only frame, loaded when select falls.
    if (q_r.mode_s2 && !q_r.ss_s2) begin
      if (ss_fall) begin
        q_nxt.spi_word = frame;                                 // RQ15
        q_nxt.fresh    = 1'b0;
        q_nxt.miso     = frame[31];
      end else if (spi_bin < `PRSR_FRAME_BITS) begin
        q_nxt.miso     = q_r.spi_word[5'h1F - spi_bin[4:0]];    // RQ16
      end else begin
        q_nxt.miso     = 1'b0;
      end
      q_nxt.miso_oe = 1'b1;
    end else begin
      // Deselect ends the frame at any byte.
      q_nxt.miso    = 1'b0;
      q_nxt.miso_oe = 1'b0;
    end

    // A new result sets the fresh flag; it wins over a clear this cycle.
    if (fifo_pop) begin
      q_nxt.sample = fifo_out_data;
      q_nxt.fresh  = 1'b1;                                      // RQ1
    end
  end

  // System-clock state register; idle lines sync as released highs.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r         <= '0;
      q_r.scl_s1  <= 1'b1;
      q_r.scl_s2  <= 1'b1;
      q_r.scl_d   <= 1'b1;
      q_r.sda_s1  <= 1'b1;
      q_r.sda_s2  <= 1'b1;
      q_r.sda_d   <= 1'b1;
      q_r.ss_s1   <= 1'b1;
      q_r.ss_s2   <= 1'b1;
      q_r.ss_d    <= 1'b1;
      q_r.state   <= prsr_pkg::I2C_IDLE;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Falling serial clock counts bits sent; saturates at one full frame.
  always_comb begin
    lk_nxt = lk_r;
    if (lk_r.bin != `PRSR_FRAME_BITS) begin
      lk_nxt.bin = lk_r.bin + 6'h01;
    end
    lk_nxt.gray = lk_nxt.bin ^ {1'b0, lk_nxt.bin[5:1]};
  end

  // Serial-clock counter, cleared while the host holds select high.
  always_ff @(negedge spi_sclk_i or posedge spi_ss_n_i) begin
    if (spi_ss_n_i) begin
      lk_r <= '0;                                               // RQ17
    end else begin
      lk_r <= lk_nxt;
    end
  end

endmodule : prsr_readout

`default_nettype wire

// [tb/prsr_chk.sv]
`default_nettype none

// Pin-level checker for the pressure readout.
module prsr_chk #(
  parameter int unsigned UPDATE_CYC = 62500
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic spi_mode_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic sda_o,
  input  wire logic sda_oe_o,
  input  wire logic spi_sclk_i,
  input  wire logic spi_ss_n_i,
  input  wire logic miso_o,
  input  wire logic miso_oe_o,
  input  wire logic data_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] age_r; // Cycles since reset release.
  logic [4:0]  rec_r; // Cycles since the host last held a clock or select low.

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Counts time since reset and since the last host activity, both saturating.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      age_r <= 32'h0;
      rec_r <= 5'h1F;
    end else begin
      age_r <= (age_r == 32'hFFFFFFFF) ? age_r : age_r + 32'h1;
      rec_r <= (!scl_i || !spi_ss_n_i) ? 5'h0 : ((rec_r == 5'h1F) ? rec_r : rec_r + 5'h1);
    end
  end

  rst_quiet_a: assert property (disable iff (1'b0) rst_i |=> !sda_oe_o && !miso_oe_o && !data_ready_o)
    else $error("Outputs active after reset.");
  sda_od_a: assert property (sda_o == 1'b0)
    else $error("Data pin driven high.");
  stop_free_a: assert property (scl_i && $past(scl_i) && $rose(sda_i) |-> ##3 (!sda_oe_o)[*6])
    else $error("Data pulled low after a stop.");
  sda_edge_a: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("Data changed while clock high.");
  miso_off_a: assert property ((spi_ss_n_i || !spi_mode_i)[*6] |-> !miso_oe_o)
    else $error("Serial output driven while deselected.");
  miso_on_a: assert property ((!spi_ss_n_i && spi_mode_i)[*6] |-> miso_oe_o)
    else $error("Serial output not driven while selected.");
  miso_hold_a: assert property (spi_sclk_i[*3] |-> $stable(miso_o))
    else $error("Serial output moved while clock high.");
  ready_drop_a: assert property ($fell(data_ready_o) |-> rec_r < 5'h10)
    else $error("Ready flag dropped without a read.");
  ready_early_a: assert property (age_r < UPDATE_CYC |-> !data_ready_o)
    else $error("Ready flag before first conversion.");
  ready_late_a: assert property (age_r == UPDATE_CYC + 12 |-> data_ready_o)
    else $error("Ready flag missing after first conversion.");

  cover property ($rose(data_ready_o));
  cover property ($rose(miso_oe_o));
  cover property ($rose(sda_oe_o));
endmodule : prsr_chk

bind prsr_readout prsr_chk #(.UPDATE_CYC(UPDATE_CYC)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .spi_mode_i(spi_mode_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .spi_sclk_i(spi_sclk_i),
  .spi_ss_n_i(spi_ss_n_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
  .data_ready_o(data_ready_o));

`default_nettype wire

// [tb/prsr_host.sv]
`default_nettype none

// Host of both serial ports; the bench calls its tasks.
module prsr_host (
  input  wire logic clk_i,
  input  wire logic sda_i,
  input  wire logic miso_i,
  output logic      scl_o,
  output logic      sda_pull_o,
  output logic      sclk_o,
  output logic      ss_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Both buses start idle and the link clock stands still.
  initial begin
    scl_o      = 1'b1;
    sda_pull_o = 1'b0;
    sclk_o     = 1'b0;
    ss_n_o     = 1'b1;
  end

  // Waits a third of a two-wire bit.
  task automatic wq();
    repeat (8) @(negedge clk_i);
  endtask : wq

  // Sends or samples one bit; data moves only while the clock is low.
  task automatic i2c_bit(input logic b, output logic r);
    sda_pull_o = !b;
    wq();
    scl_o = 1'b1;
    wq();
    r = sda_i;
    scl_o = 1'b0;
    wq();
  endtask : i2c_bit

  // Start condition, also usable as a repeated start.
  task automatic i2c_start();
    sda_pull_o = 1'b0;
    wq();
    scl_o = 1'b1;
    wq();
    sda_pull_o = 1'b1;
    wq();
    scl_o = 1'b0;
  endtask : i2c_start

  // Stop condition that leaves both lines high.
  task automatic i2c_stop();
    sda_pull_o = 1'b1;
    wq();
    scl_o = 1'b1;
    wq();
    sda_pull_o = 1'b0;
    wq();
  endtask : i2c_stop

  // Start directly followed by stop, no clock pulse between.
  task automatic i2c_glitch();
    sda_pull_o = 1'b1;
    wq();
    sda_pull_o = 1'b0;
    wq();
  endtask : i2c_glitch

  // Read of n bytes; rs breaks off with a repeated start after byte one.
  task automatic i2c_read(input logic [6:0] a, input int n, input bit rs,
                          output logic nak, output logic [31:0] d);
    logic [7:0] ab;
    logic       b;
    int         i;
    ab = {a, 1'b1};
    d = 32'h0;
    i2c_start();
    for (i = 7; i >= 0; i--) begin
      i2c_bit(ab[i], b);
    end
    i2c_bit(1'b1, nak);
    for (i = 0; i < n * 8 && !nak; i++) begin
      i2c_bit(1'b1, b);
      d = {d[30:0], b};
      if (i % 8 == 7) begin
        if (rs) begin
          i2c_start();
          i = n * 8;
        end else begin
          i2c_bit(i == n * 8 - 1, b);
        end
      end
    end
    i2c_stop();
  endtask : i2c_read

  // Three-wire read of n bytes, sampled at each rising edge of a 64 ns clock.
  task automatic spi_read(input int n, output logic [31:0] d);
    int i;
    d = 32'h0;
    #3 ss_n_o = 1'b0;
    #77;
    for (i = 0; i < n * 8; i++) begin
      d = {d[30:0], miso_i};
      sclk_o = 1'b1;
      #24 sclk_o = 1'b0;
      #40;
    end
    ss_n_o = 1'b1;
    #80;
  endtask : spi_read
endmodule : prsr_host

`default_nettype wire

// [tb/prsr_readout_test.sv]
`include "prsr_params.svh"
`default_nettype none

// Self-checking bench for the pressure readout.
module prsr_readout_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned UPD = 2000; // Shortened update interval.
  logic                     clk;
  logic                     rst;
  logic                     mode;
  logic [`PRSR_PRESS_W-1:0] pres;
  logic [`PRSR_TEMP_W-1:0]  temp;
  logic                     scl, pull, sclk, ss_n;
  logic                     sda_oe, miso, miso_oe, rdy;
  logic                     sda;    // Data wire with its pull-up.
  logic                     miso_w; // Serial line as the host sees it.
  int                       errors, checks, cyc, seed, last_blk, r;

  assign sda = !(pull || sda_oe);
  // A released serial line shows a toggling pattern, not its last value.
  assign miso_w = miso_oe ? miso : clk;

  prsr_readout #(.UPDATE_CYC(UPD), .EXTRA_CYC(100)) u_dut (
    .clk_i(clk), .rst_i(rst), .pressure_i(pres), .temperature_i(temp),
    .spi_mode_i(mode), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
    .spi_sclk_i(sclk), .spi_ss_n_i(ss_n), .miso_o(miso), .miso_oe_o(miso_oe),
    .data_ready_o(rdy));
  prsr_host u_host (.clk_i(clk), .sda_i(sda), .miso_i(miso_w), .scl_o(scl),
    .sda_pull_o(pull), .sclk_o(sclk), .ss_n_o(ss_n));

  // System clock of 8 ns.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Cycle count since reset release, with a ceiling against hangs.
  always @(posedge clk) begin
    cyc <= rst ? 0 : cyc + 1;
    if (cyc > 20000) begin
      errors++;
      finish_test();
    end
  end

  // Compares one result and reports a mismatch.
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check

  // Waits for the next time the cycle count reaches phase 100 of an update interval.
  task automatic sync();
    do @(negedge clk); while (cyc % UPD != 100);
  endtask : sync

  // Reads n bytes and compares with the frame the model expects.
  task automatic rd(input bit spi, input int n, input bit rs);
    logic        nak;
    logic [31:0] d;
    logic [1:0]  st;
    int          blk;
    blk = cyc / UPD;
    st = (blk != last_blk) ? `PRSR_ST_FRESH : `PRSR_ST_STALE;
    last_blk = blk;
    if (spi) begin
      u_host.spi_read(n, d);
    end else begin
      u_host.i2c_read(`PRSR_ADDR, n, rs, nak, d);
      check({31'h0, nak}, 32'h0);
    end
    check(d, {st, pres, temp, 5'h0} >> (32 - 8 * n));
  endtask : rd

  // A read that must go unanswered.
  task automatic bad(input logic [6:0] a);
    logic        nak;
    logic [31:0] d;
    u_host.i2c_read(a, 1, 1'b0, nak, d);
    check({31'h0, nak}, 32'h1);
  endtask : bad

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  // Main sequence.
  initial begin
    logic [31:0] d;
    rst = 1'b1;
    mode = 1'b1;
    errors = 0;
    checks = 0;
    cyc = 0;
    last_blk = 0;
    seed = 43425;
    pres = 14'($random(seed));
    temp = 11'($random(seed));
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (UPD) @(negedge clk);
    // Two, three and four bytes on each port: fresh, then stale.
    for (r = 0; r < 3; r++) begin
      sync();
      rd(1'b0, r + 2, 1'b0);
      rd(1'b1, r + 2, 1'b0);
      pres = 14'($random(seed));
      temp = 11'($random(seed));
    end
    sync();
    bad(7'h29);
    u_host.i2c_glitch();
    bad(`PRSR_ADDR);
    rd(1'b0, 4, 1'b0);
    sync();
    rd(1'b0, 1, 1'b1);
    bad(`PRSR_ADDR);
    rd(1'b0, 2, 1'b0);
    mode = 1'b0;
    u_host.spi_read(2, d);
    check({31'h0, miso_oe}, 32'h0);
    finish_test();
  end
endmodule : prsr_readout_test

`default_nettype wire
